// >>> hw/actr_pkg.sv
// Package: register map, field positions and reset values of the channel control block
package actr_pkg;
  localparam int          NUM_CH        = 21;
  localparam int          LO_BITS       = 16;
  localparam int          HI_BITS       = 5;
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFF_LVL_LO    = 8'h00;
  localparam logic [7:0]  OFF_LVL_HI    = 8'h04;
  localparam logic [7:0]  OFF_EIE_LO    = 8'h08;
  localparam logic [7:0]  OFF_EIE_HI    = 8'h0c;
  localparam logic [7:0]  OFF_STAT_LO   = 8'h10;
  localparam logic [7:0]  OFF_STAT_HI   = 8'h14;
  localparam logic [7:0]  OFF_MODE      = 8'h18;
  localparam logic [7:0]  OFF_IE_LO     = 8'h1c;
  localparam logic [7:0]  OFF_IE_HI     = 8'h20;
  localparam logic [7:0]  OFF_LEAD      = 8'h24;
  localparam int          MODE_SIGN0    = 0;
  localparam int          MODE_DIFF0    = 1;
  localparam int          MODE_SIGN1    = 2;
  localparam int          MODE_DIFF1    = 3;
  localparam int          MODE_BITS     = 4;
  localparam int          LEAD_BITS     = 3;
  localparam logic [20:0] CH_RESET      = 21'h000000;
  localparam logic [3:0]  MODE_RESET    = 4'h0;
  localparam logic [2:0]  LEAD_RESET    = 3'h0;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  CONV_TICKS    = 5'h0e;
endpackage

// >>> hw/actr_trig_cond.sv
// Trigger conditioning: level or edge sensitivity per input
`timescale 1ns/10ps
`default_nettype none
module actr_trig_cond #(
  parameter int N = 21
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [N-1:0] trig_in,
  input  wire logic [N-1:0] level_sel_in,
  output logic      [N-1:0] req_out
);
  logic [N-1:0] trig_q;
  logic [N-1:0] next_trig_q;

  always_comb begin
    next_trig_q = trig_in;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      trig_q <= '0;
    end else begin
      trig_q <= next_trig_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      // Level mode requests while high; edge mode only on the rising edge
      assign req_out[g] = level_sel_in[g] ? trig_in[g] : (trig_in[g] & ~trig_q[g]); // RULE_01
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hw/actr_conv_timer.sv
// Conversion timer for one input: counts core clock periods, flags early and ready
`timescale 1ns/10ps
`default_nettype none
module actr_conv_timer
  import actr_pkg::*;
#(
  parameter logic [4:0] TICKS = CONV_TICKS
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       start_in,
  input  wire logic       core_tick_in,
  input  wire logic [2:0] lead_sel_in,
  output logic            busy_out,
  output logic            early_out,
  output logic            ready_out
);
  logic [4:0] count;
  logic [4:0] next_count;
  logic [4:0] lead;

  // Lead of 1..8 periods; needs TICKS above 8 or the early flag is missed
  assign lead     = {2'b00, lead_sel_in} + 5'h01;
  assign busy_out = (count != 5'h00);

  always_comb begin
    next_count = count;
    if (!busy_out && start_in) begin
      next_count = TICKS;
    end else if (busy_out && core_tick_in) begin
      next_count = count - 5'h01;
    end
  end

  always_comb begin
    early_out = busy_out && core_tick_in && (count == lead + 5'h01); // RULE_11
    ready_out = busy_out && core_tick_in && (count == 5'h01);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= 5'h00;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// >>> hw/actr_channel_regs.sv
// Per-channel trigger, early interrupt and mode control registers on APB
//
// Functional notes
// RULE_01 - Level select 1 level trigger, 0 edge
// RULE_02 - Inputs 15-0 low word, 20-16 high
// RULE_03 - Early interrupt only when its enable set
// RULE_04 - Early interrupt sets the status bit
// RULE_05 - Result buffer read clears status bit
// RULE_06 - Differential bits at 1 and 3
// RULE_07 - Signed output bits at 0 and 2
// RULE_08 - Enable gates common and individual interrupts
// RULE_09 - Unused upper bits read zero
// RULE_10 - All bits clear on reset
// RULE_11 - Early interrupt 1 to 8 periods ahead
// RULE_12 - Status readable; writing 0 clears
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module actr_channel_regs #(
  parameter int N = actr_pkg::NUM_CH
) (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [actr_pkg::ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  output logic      [31:0]                 prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  input  wire logic [N-1:0]                trig_in,
  input  wire logic                        core_tick_in,
  input  wire logic [N-1:0]                buf_read_in,
  output logic      [N-1:0]                conv_busy_out,
  output logic      [N-1:0]                data_ready_out,
  output logic      [N-1:0]                early_irq_out,
  output logic      [N-1:0]                chan_irq_out,
  output logic                             common_irq_out,
  output logic      [1:0]                  differential_mode_out,
  output logic      [1:0]                  signed_out
);
  import actr_pkg::*;

  logic [N-1:0]         level_trigger_select;
  logic [N-1:0]         early_irq_enable;
  logic [N-1:0]         early_irq_status;
  logic [N-1:0]         channel_irq_enable;
  logic [MODE_BITS-1:0] input_mode_control;
  logic [LEAD_BITS-1:0] early_irq_lead_select;
  logic [N-1:0]         next_level_trigger_select;
  logic [N-1:0]         next_early_irq_enable;
  logic [N-1:0]         next_early_irq_status;
  logic [N-1:0]         next_channel_irq_enable;
  logic [MODE_BITS-1:0] next_input_mode_control;
  logic [LEAD_BITS-1:0] next_early_irq_lead_select;
  logic [31:0]          prdata;
  logic [31:0]          next_prdata;
  logic                 rd_err;
  logic                 next_rd_err;
  logic                 wr_acc;
  logic                 setup;
  logic                 mapped;
  logic [31:0]          rd_mux;
  logic [N-1:0]         conv_req;
  logic [N-1:0]         early_raw;
  logic [N-1:0]         early_evt;
  logic [N-1:0]         ready_raw;
  logic [N-1:0]         stat_keep;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, read data captured in the setup cycle
  assign setup       = psel_in && !penable_in;
  assign wr_acc      = psel_in && penable_in && pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && rd_err;
  assign prdata_out  = prdata;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    unique case (paddr_in)
      OFF_LVL_LO:  rd_mux[LO_BITS-1:0] = level_trigger_select[LO_BITS-1:0]; // RULE_02
      OFF_LVL_HI:  rd_mux[HI_BITS-1:0] = level_trigger_select[N-1:LO_BITS]; // RULE_09
      OFF_EIE_LO:  rd_mux[LO_BITS-1:0] = early_irq_enable[LO_BITS-1:0];
      OFF_EIE_HI:  rd_mux[HI_BITS-1:0] = early_irq_enable[N-1:LO_BITS];
      OFF_STAT_LO: rd_mux[LO_BITS-1:0] = early_irq_status[LO_BITS-1:0]; // RULE_12
      OFF_STAT_HI: rd_mux[HI_BITS-1:0] = early_irq_status[N-1:LO_BITS];
      OFF_MODE:    rd_mux[MODE_BITS-1:0] = input_mode_control; // RULE_09
      OFF_IE_LO:   rd_mux[LO_BITS-1:0] = channel_irq_enable[LO_BITS-1:0];
      OFF_IE_HI:   rd_mux[HI_BITS-1:0] = channel_irq_enable[N-1:LO_BITS];
      OFF_LEAD:    rd_mux[LEAD_BITS-1:0] = early_irq_lead_select;
      default:     mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_prdata = prdata;
    next_rd_err = rd_err;
    if (setup) begin
      next_prdata = rd_mux;
      next_rd_err = !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; writes land at the access edge
  always_comb begin
    next_level_trigger_select  = level_trigger_select;
    next_early_irq_enable      = early_irq_enable;
    next_channel_irq_enable    = channel_irq_enable;
    next_input_mode_control    = input_mode_control;
    next_early_irq_lead_select = early_irq_lead_select;
    if (wr_acc) begin
      unique case (paddr_in)
        OFF_LVL_LO: next_level_trigger_select[LO_BITS-1:0] = pwdata_in[LO_BITS-1:0]; // RULE_02
        OFF_LVL_HI: next_level_trigger_select[N-1:LO_BITS] = pwdata_in[HI_BITS-1:0]; // RULE_02
        OFF_EIE_LO: next_early_irq_enable[LO_BITS-1:0] = pwdata_in[LO_BITS-1:0];
        OFF_EIE_HI: next_early_irq_enable[N-1:LO_BITS] = pwdata_in[HI_BITS-1:0];
        OFF_MODE:   next_input_mode_control = pwdata_in[MODE_BITS-1:0];
        OFF_IE_LO:  next_channel_irq_enable[LO_BITS-1:0] = pwdata_in[LO_BITS-1:0];
        OFF_IE_HI:  next_channel_irq_enable[N-1:LO_BITS] = pwdata_in[HI_BITS-1:0];
        OFF_LEAD:   next_early_irq_lead_select = pwdata_in[LEAD_BITS-1:0];
        default:    next_level_trigger_select = level_trigger_select;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status: a new event beats a clear by write or by a buffer read
  always_comb begin
    stat_keep = ~buf_read_in; // RULE_05
    if (wr_acc && paddr_in == OFF_STAT_LO) begin
      stat_keep[LO_BITS-1:0] = stat_keep[LO_BITS-1:0] & pwdata_in[LO_BITS-1:0]; // RULE_12
    end
    if (wr_acc && paddr_in == OFF_STAT_HI) begin
      stat_keep[N-1:LO_BITS] = stat_keep[N-1:LO_BITS] & pwdata_in[HI_BITS-1:0]; // RULE_12
    end
    next_early_irq_status = (early_irq_status & stat_keep) | early_evt; // RULE_04
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_trigger_select  <= CH_RESET; // RULE_10
      early_irq_enable      <= CH_RESET;
      early_irq_status      <= CH_RESET;
      channel_irq_enable    <= CH_RESET;
      input_mode_control    <= MODE_RESET;
      early_irq_lead_select <= LEAD_RESET;
      prdata                <= 32'h00000000;
      rd_err                <= 1'b0;
    end else begin
      level_trigger_select  <= next_level_trigger_select;
      early_irq_enable      <= next_early_irq_enable;
      early_irq_status      <= next_early_irq_status;
      channel_irq_enable    <= next_channel_irq_enable;
      input_mode_control    <= next_input_mode_control;
      early_irq_lead_select <= next_early_irq_lead_select;
      prdata                <= next_prdata;
      rd_err                <= next_rd_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion path
  actr_trig_cond #(
    .N (N)
  ) u_trig (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .trig_in      (trig_in),
    .level_sel_in (level_trigger_select),
    .req_out      (conv_req)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      actr_conv_timer u_tmr (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .start_in     (conv_req[g]),
        .core_tick_in (core_tick_in),
        .lead_sel_in  (early_irq_lead_select),
        .busy_out     (conv_busy_out[g]),
        .early_out    (early_raw[g]),
        .ready_out    (ready_raw[g])
      );
    end
  endgenerate

  // Early events are dropped, not deferred, while disabled
  assign early_evt             = early_raw & early_irq_enable; // RULE_03
  assign early_irq_out         = early_evt;
  assign data_ready_out        = ready_raw;
  assign chan_irq_out          = ready_raw & channel_irq_enable; // RULE_08
  assign common_irq_out        = |(ready_raw & channel_irq_enable); // RULE_08
  assign differential_mode_out = {input_mode_control[MODE_DIFF1],
                                  input_mode_control[MODE_DIFF0]}; // RULE_06
  assign signed_out            = {input_mode_control[MODE_SIGN1],
                                  input_mode_control[MODE_SIGN0]}; // RULE_07

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  edge_no_repeat_a: assert property ( // RULE_01
    !level_trigger_select[0] && trig_in[0] && $past(trig_in[0]) |-> !conv_req[0])
    else $error("edge trigger requested on a held level");

  level_follow_a: assert property ( // RULE_01
    level_trigger_select[0] && trig_in[0] |-> conv_req[0])
    else $error("level trigger did not request");

  hi_write_lands_a: assert property ( // RULE_02
    wr_acc && paddr_in == OFF_LVL_HI |=> level_trigger_select[N-1:LO_BITS] ==
    $past(pwdata_in[HI_BITS-1:0]))
    else $error("high select write lost");

  early_gate_a: assert property ( // RULE_03
    early_raw[0] && !early_irq_enable[0] |-> !early_irq_out[0] ##1 !early_irq_status[0] ||
    $past(early_irq_status[0]))
    else $error("early interrupt while disabled");

  status_set_a: assert property ( // RULE_04
    early_evt[0] |=> early_irq_status[0])
    else $error("status not set by early event");

  buf_clear_a: assert property ( // RULE_05
    buf_read_in[0] && !early_evt[0] |=> !early_irq_status[0])
    else $error("buffer read did not clear status");

  mode_write_a: assert property ( // RULE_06
    wr_acc && paddr_in == OFF_MODE |=> differential_mode_out[1] == $past(pwdata_in[3]) &&
    signed_out[0] == $past(pwdata_in[0]))
    else $error("mode bits not at documented positions");

  irq_enable_a: assert property ( // RULE_08
    chan_irq_out[0] |-> channel_irq_enable[0] && data_ready_out[0] && common_irq_out)
    else $error("channel interrupt without enable");

  upper_zero_a: assert property ( // RULE_09
    setup && (paddr_in == OFF_LVL_HI || paddr_in == OFF_MODE) |=> prdata_out[31:5] == 27'h0 &&
    (!$past(paddr_in == OFF_MODE) || prdata_out[4] == 1'b0))
    else $error("unused bits read nonzero");

  early_lead_a: assert property ( // RULE_11
    early_raw[0] && early_irq_lead_select == 3'h0 |-> ##[1:1000] ready_raw[0])
    else $error("ready did not follow early flag");

  stat_wr0_a: assert property ( // RULE_12
    wr_acc && paddr_in == OFF_STAT_LO && !pwdata_in[0] && !early_evt[0] |=>
    !early_irq_status[0])
    else $error("writing zero did not clear status");

  ////////////////////////////////////////////////////////////////////////////
  // Field placement on both words, flag priority and gating of the high inputs

  edge_start_a: assert property ( // RULE_01
    !level_trigger_select[0] && trig_in[0] && !$past(trig_in[0]) |-> conv_req[0])
    else $error("edge trigger did not request");

  lo_write_lands_a: assert property ( // RULE_02
    wr_acc && paddr_in == OFF_LVL_LO |=> level_trigger_select[LO_BITS-1:0] ==
    $past(pwdata_in[LO_BITS-1:0]))
    else $error("low select write lost");

  eie_hi_write_a: assert property ( // RULE_03
    wr_acc && paddr_in == OFF_EIE_HI |=> early_irq_enable[N-1:LO_BITS] ==
    $past(pwdata_in[HI_BITS-1:0]))
    else $error("high early enable write lost");

  set_beats_clear_a: assert property ( // RULE_04
    early_evt[1] && buf_read_in[1] |=> early_irq_status[1])
    else $error("clear won over a new early event");

  status_hi_set_a: assert property ( // RULE_04
    early_evt[20] |=> early_irq_status[20])
    else $error("high status not set by early event");

  status_hold_a: assert property ( // RULE_05
    early_irq_status[0] && !buf_read_in[0] &&
    !(wr_acc && paddr_in == OFF_STAT_LO && !pwdata_in[0]) |=> early_irq_status[0])
    else $error("status dropped without a clear");

  sign_pos_a: assert property ( // RULE_07
    wr_acc && paddr_in == OFF_MODE |=> signed_out[1] == $past(pwdata_in[2]) &&
    differential_mode_out[0] == $past(pwdata_in[1]))
    else $error("mode bits not at their positions");

  ready_gate_a: assert property ( // RULE_08
    data_ready_out[20] && channel_irq_enable[20] |-> chan_irq_out[20] && common_irq_out)
    else $error("enabled ready raised no interrupt");

  ie_hi_write_a: assert property ( // RULE_08
    wr_acc && paddr_in == OFF_IE_HI |=> channel_irq_enable[N-1:LO_BITS] ==
    $past(pwdata_in[HI_BITS-1:0]))
    else $error("high interrupt enable write lost");

  hi_words_zero_a: assert property ( // RULE_09
    setup && (paddr_in == OFF_EIE_HI || paddr_in == OFF_STAT_HI ||
    paddr_in == OFF_IE_HI) |=> prdata_out[31:HI_BITS] == 27'h0)
    else $error("unused high bits read nonzero");

  early_ahead_a: assert property ( // RULE_11
    early_raw[0] |-> !ready_raw[0])
    else $error("early flag not ahead of ready");

  status_read_a: assert property ( // RULE_12
    setup && paddr_in == OFF_STAT_LO |=> prdata_out[LO_BITS-1:0] ==
    $past(early_irq_status[LO_BITS-1:0]))
    else $error("status read does not match the flags");

  stat_wr1_a: assert property ( // RULE_12
    wr_acc && paddr_in == OFF_STAT_HI && pwdata_in[4] && early_irq_status[20] &&
    !buf_read_in[20] |=> early_irq_status[20])
    else $error("writing one cleared status");

  early_seen_c: cover property (early_evt[0] ##[1:20] ready_raw[0]);
  common_seen_c: cover property (common_irq_out);
  set_over_clear_c: cover property (early_evt[1] && buf_read_in[1]);
  unmapped_c: cover property (pslverr_out);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the per-channel control registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import actr_pkg::*;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [20:0] trig = '0;
  logic [20:0] buf_read = '0;
  logic        core_tick = 1'b0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [20:0] conv_busy_out;
  logic [20:0] data_ready_out;
  logic [20:0] early_irq_out;
  logic [20:0] chan_irq_out;
  logic        common_irq_out;
  logic [1:0]  differential_mode_out;
  logic [1:0]  signed_out;
  integer      seed = 32'hdb50;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c, 8'h20, 8'h24};
  logic [31:0] masks [8] = '{32'hffff, 32'h1f, 32'hffff, 32'h1f, 32'hf, 32'hffff, 32'h1f, 32'h7};
  int          chs [5] = '{0, 20, 15, 16, 0};

  actr_channel_regs i_actr_channel_regs (
    .clk_in                (clk_in),
    .resetn_in             (resetn_in),
    .psel_in               (psel),
    .penable_in            (penable),
    .pwrite_in             (pwrite),
    .paddr_in              (paddr),
    .pwdata_in             (pwdata),
    .prdata_out            (prdata_out),
    .pready_out            (pready_out),
    .pslverr_out           (pslverr_out),
    .trig_in               (trig),
    .core_tick_in          (core_tick),
    .buf_read_in           (buf_read),
    .conv_busy_out         (conv_busy_out),
    .data_ready_out        (data_ready_out),
    .early_irq_out         (early_irq_out),
    .chan_irq_out          (chan_irq_out),
    .common_irq_out        (common_irq_out),
    .differential_mode_out (differential_mode_out),
    .signed_out            (signed_out)
  );

  always #5 clk_in = ~clk_in;
  // Core period of two clocks, so the lead count is visible in clock cycles
  always @(posedge clk_in) core_tick <= ~core_tick;

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each transfer starts one edge after the last release, never in the same step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // No wait limit of its own; the bench timeout ends a hang
    while (pready_out !== 1'b1) begin
      @(posedge clk_in);
    end
    q = prdata_out;
    err = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Tick count at which the early flag shows, or all ones when it must not
  function automatic logic [31:0] exp_early(input logic en, input logic [2:0] sel);
    return en ? 32'(int'(CONV_TICKS) - int'(sel) - 1) : 32'hffffffff;
  endfunction

  // One channel bit split over the low and high words
  task automatic cfg(input logic [7:0] a, input int ch, input logic v);
    wr(a, ch < 16 ? 32'(v) << ch : 32'h0);
    wr(a + 8'h04, ch >= 16 ? 32'(v) << (ch - 16) : 32'h0);
  endtask

  task automatic rd_ch(input logic [7:0] a, output logic [20:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    v = {hi[4:0], lo[15:0]};
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
    logic [20:0] st;
    logic [2:0]  lead;
    logic        eie;
    logic        ie;
    logic        lvl;
    int          ch;
    int          ticks;
    int          e_at;
    int          r_at;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int a = 0; a < 40; a += 4) begin
      rd(8'(a), q);
      chk(q, 32'h0);
    end
    chk(32'({differential_mode_out, signed_out, conv_busy_out}), 32'h0);
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 8; j++) begin
        d = $random(seed);
        wr(offs[j], d);
        rd(offs[j], q);
        chk(q, d & masks[j]);
        if (offs[j] == OFF_MODE) begin
          chk(32'(differential_mode_out), 32'({d[3], d[1]}));
          chk(32'(signed_out), 32'({d[2], d[0]}));
        end
      end
      wr(OFF_STAT_LO, $random(seed));
      rd(OFF_STAT_LO, q);
      chk(q, 32'h0);
    end
    // Unmapped place: refused with an error, reads zero
    apb(1'b1, 8'h28, 32'hffffffff, q, e);
    apb(1'b0, 8'h28, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    for (int i = 0; i < 10; i++) begin
      d = $random(seed);
      ch = i < 5 ? chs[i] : int'(d[15:8] % 21);
      lead = i == 0 ? 3'h0 : (i == 1 ? 3'h7 : d[18:16]);
      eie = (i != 2) && (i < 2 || d[0]);
      ie = (i != 3) && (i < 3 || d[1]);
      lvl = (i == 2) || (i == 4) || (i != 0 && d[2]);
      wr(OFF_LEAD, 32'(lead));
      cfg(OFF_LVL_LO, ch, lvl);
      cfg(OFF_EIE_LO, ch, eie);
      cfg(OFF_IE_LO, ch, ie);
      @(posedge clk_in);
      trig <= 21'h1 << ch;
      ticks = 0;
      e_at = -1;
      r_at = -1;
      for (int k = 0; k < 200 && r_at < 0; k++) begin
        @(negedge clk_in);
        if (conv_busy_out[ch] && core_tick) ticks++;
        if (early_irq_out[ch]) e_at = ticks;
        if (data_ready_out[ch]) begin
          r_at = ticks;
          chk(32'(chan_irq_out[ch]), 32'(ie));
          chk(32'(common_irq_out), 32'(ie));
        end
      end
      chk(32'(r_at), 32'(CONV_TICKS));
      chk(32'(e_at), exp_early(eie, lead));
      // Trigger still high: only a level trigger starts again
      repeat (3) @(negedge clk_in);
      chk(32'(conv_busy_out[ch]), 32'(lvl));
      @(posedge clk_in);
      trig <= '0;
      for (int k = 0; k < 100 && conv_busy_out[ch]; k++) @(negedge clk_in);
      rd_ch(OFF_STAT_LO, st);
      chk(32'(st), 32'(eie) << ch);
      if (i % 2 == 1) begin
        @(posedge clk_in);
        buf_read <= 21'h1 << ch;
        @(posedge clk_in);
        buf_read <= '0;
      end else begin
        wr(OFF_STAT_LO, 32'h0);
        wr(OFF_STAT_HI, 32'h0);
      end
      rd_ch(OFF_STAT_LO, st);
      chk(32'(st), 32'h0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
